//--- common/mstm_pkg.sv
/*
 * mstm_pkg: constants for the multilane sample transport mapper.
 * Register map, fields, resets and per-format tables indexed by code.
 * Assumes: every consumer imports the whole package.
 */
package mstm_pkg;
    localparam int MSTM_LANES = 8;
    localparam int MSTM_SMP_W = 12;
    localparam int MSTM_NCH = 4;
    localparam int MSTM_SPC = 20;
    localparam int MSTM_FRAME_W = 64;
    localparam int MSTM_MODES = 16;

    // register byte offsets
    localparam logic [7:0] MSTM_CTRL_OFS = 8'h00;
    localparam logic [7:0] MSTM_MFRAME_OFS = 8'h04;
    localparam logic [7:0] MSTM_SCLK_OFS = 8'h08;
    localparam logic [7:0] MSTM_STATUS_OFS = 8'h0C;
    localparam logic [7:0] MSTM_PARAMS_OFS = 8'h10;
    localparam logic [7:0] MSTM_KRATE_OFS = 8'h14;
    localparam logic [7:0] MSTM_LANES_OFS = 8'h18;

    // field positions
    localparam int MSTM_CTRL_EN_BIT = 0;
    localparam int MSTM_CTRL_SCR_BIT = 1;
    localparam int MSTM_CTRL_FMT_LSB = 8;
    localparam int MSTM_CTRL_DID_LSB = 16;
    localparam int MSTM_ST_FMT_REJ_BIT = 0;
    localparam int MSTM_ST_KM1_REJ_BIT = 1;
    localparam int MSTM_ST_LOCK_REJ_BIT = 2;
    localparam int MSTM_ST_K_BAD_BIT = 3;
    localparam int MSTM_ST_CLK_BAD_BIT = 4;
    localparam int MSTM_ST_ACTIVE_BIT = 5;
    localparam int MSTM_ST_ENC64_BIT = 6;
    localparam int MSTM_KRATE_RATE_LSB = 16;

    // reset values
    localparam logic [3:0] MSTM_FMT_RST = 4'h0;
    localparam logic [7:0] MSTM_KM1_RST = 8'h1F;
    localparam logic [7:0] MSTM_DID_RST = 8'h00;
    localparam logic [15:0] MSTM_SCLK_RST = 16'h3E80;

    // link constants; clock figures in units of 0.1 MHz
    localparam logic [7:0] MSTM_JESDV = 8'h01;
    localparam logic [7:0] MSTM_SUBCLASSV = 8'h01;
    localparam logic [15:0] MSTM_FCLK_MIN = 16'h1388;
    localparam logic [9:0] MSTM_EMB_FRAMES = 10'h100;

    // per-format tables
    localparam logic MSTM_TBL_ENC64 [0:15] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1,
        1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
    localparam logic [3:0] MSTM_TBL_N [0:15] = '{4'hC, 4'hC, 4'h8, 4'hA, 4'hC, 4'h8, 4'hC, 4'h8,
        4'hC, 4'h8, 4'hA, 4'hC, 4'h8, 4'hA, 4'hC, 4'hC};
    localparam logic [3:0] MSTM_TBL_L [0:15] = '{4'h8, 4'h6, 4'h4, 4'h4, 4'h3, 4'h2, 4'h6, 4'h4,
        4'h4, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8};
    localparam logic [3:0] MSTM_TBL_M [0:15] = '{4'h8, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
        4'h4, 4'h4, 4'h8, 4'h8, 4'h2, 4'h8, 4'h8, 4'h8};
    localparam logic [3:0] MSTM_TBL_F [0:15] = '{4'h8, 4'h2, 4'h1, 4'h5, 4'h2, 4'h2, 4'h2, 4'h1,
        4'h3, 4'h1, 4'h5, 4'h8, 4'h1, 4'h5, 4'h3, 4'h3};
    localparam logic [3:0] MSTM_TBL_S [0:15] = '{4'h5, 4'h2, 4'h1, 4'h4, 4'h1, 4'h1, 4'h2, 4'h1,
        4'h2, 4'h2, 4'h4, 4'h5, 4'h4, 4'h4, 4'h2, 4'h2};
    localparam logic [1:0] MSTM_TBL_HD [0:15] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    localparam logic [1:0] MSTM_TBL_E [0:15] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
    localparam logic [8:0] MSTM_TBL_KSTEP [0:15] = '{9'h004, 9'h010, 9'h020, 9'h020, 9'h001, 9'h001,
        9'h001, 9'h001, 9'h001, 9'h020, 9'h020, 9'h004, 9'h020, 9'h020, 9'h001, 9'h001};
    localparam logic [11:0] MSTM_TBL_RATE32 [0:15] = '{12'h100, 12'h140, 12'h140, 12'h190, 12'h210,
        12'h210, 12'h108, 12'h108, 12'h18C, 12'h0A0, 12'h0C8, 12'h080, 12'h050, 12'h064, 12'h0C6, 12'h063};
    localparam logic [15:0] MSTM_TBL_FMAX [0:15] = '{16'h3E80, 16'h3E80, 16'h3E80, 16'h35A0, 16'h28A0,
        16'h28A0, 16'h3E80, 16'h3E80, 16'h362B, 16'h3E80, 16'h3E80, 16'h3E80, 16'h3E80, 16'h3E80, 16'h3E80,
        16'h3E80};
    localparam logic [2:0] MSTM_TBL_NCH [0:15] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
        3'h4, 3'h4, 3'h4, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2};
    localparam logic [4:0] MSTM_TBL_SPC [0:15] = '{5'h0A, 5'h02, 5'h01, 5'h04, 5'h01, 5'h01, 5'h02, 5'h01,
        5'h02, 5'h02, 5'h08, 5'h14, 5'h04, 5'h10, 5'h04, 5'h08};
endpackage

//--- hdl/mstm_lane_pack.sv
/*
 * mstm_lane_pack: builds one lane's frame from a frame's worth of samples.
 * Assumes: samples arrive channel-major, each in a 12-bit slot MSB-aligned;
 * the caller registers the frame. Output is combinational.
 */
`timescale 1ns/1ps
module mstm_lane_pack
    import mstm_pkg::*;
#(
    parameter int LANE = 0,
    parameter int SMP_W = MSTM_SMP_W,
    parameter int NCH = MSTM_NCH,
    parameter int SPC = MSTM_SPC,
    parameter int FRAME_W = MSTM_FRAME_W
) (
    input wire logic [3:0] cfg_n, // sample resolution in bits
    input wire logic [3:0] cfg_f, // octets per lane frame
    input wire logic [2:0] cfg_nch, // physical channels carried
    input wire logic [4:0] cfg_spc, // samples per channel per frame
    input wire logic cfg_interleave, // lanes of one channel in time order
    input wire logic [NCH*SPC*SMP_W-1:0] sample_data, // channel-major sample slots
    output logic [FRAME_W-1:0] frame // first transmitted bit at the top
);
    logic [2:0] own_ch;
    logic [2:0] own_phase;
    logic [2:0] phase_mask;

    // channel and sample phase of this lane in time order
    always_comb begin
        if (cfg_nch == 3'h2) begin
            own_ch = 3'(LANE >> 2);
            own_phase = 3'(LANE & 3);
            phase_mask = 3'h3;
        end else begin
            own_ch = 3'(LANE >> 1);
            own_phase = 3'(LANE & 1);
            phase_mask = 3'h1;
        end
    end

    always_comb begin
        int pos;
        int lo;
        int g;
        logic take;
        pos = 0;
        g = 0;
        take = 1'b0;
        // time-order lanes start at zero, others cut one stream
        lo = cfg_interleave ? 0 : LANE * int'(cfg_f) * 8;
        frame = '0;
        for (int ch = 0; ch < NCH; ch++) begin
            for (int s = 0; s < SPC; s++) begin
                take = (ch < int'(cfg_nch)) && (s < int'(cfg_spc));
                if (cfg_interleave) begin
                    take = take && (ch == int'(own_ch)) && ((s & int'(phase_mask)) == int'(own_phase));
                end
                if (take) begin
                    for (int j = 0; j < SMP_W; j++) begin
                        g = pos + j - lo;
                        if (j < int'(cfg_n) && g >= 0 && g < int'(cfg_f) * 8) begin
                            frame[FRAME_W-1-g] = sample_data[(ch*SPC+s)*SMP_W+SMP_W-1-j];
                        end
                    end
                    pos = pos + int'(cfg_n);
                end
            end
        end
    end
endmodule

//--- hdl/mstm_mapper.sv
/*
 * mstm_mapper: transport-layer framing for a four-channel sampling converter.
 * APB registers, format lookup, lane packers, multiframe count, checksums.
 * Assumes: pclk is the sample clock; one frame of samples per accepted beat;
 * link coding, scrambling and serializers sit downstream.
 */
`timescale 1ns/1ps
module mstm_mapper
    import mstm_pkg::*;
#(
    parameter int LANES = MSTM_LANES,
    parameter int SMP_W = MSTM_SMP_W,
    parameter int NCH = MSTM_NCH,
    parameter int SPC = MSTM_SPC,
    parameter int FRAME_W = MSTM_FRAME_W
) (
    input wire logic pclk, // sample clock
    input wire logic presetn, // async reset, active low
    input wire logic [7:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sample_valid, // a frame of samples is offered
    output logic sample_ready, // mapper takes the frame
    input wire logic [NCH*SPC*SMP_W-1:0] sample_data, // channel-major slots
    output logic [LANES*FRAME_W-1:0] lane_frame_data, // per-lane frames
    output logic lane_frame_valid, // frames updated this cycle
    output logic multiframe_start, // frame opens a multiframe
    output logic [LANES-1:0] lane_power_down, // lane driver off
    output logic [LANES*5-1:0] lane_index_identifier, // per-lane id
    output logic [7:0] link_device_identifier, // id shared by all lanes
    output logic [LANES*8-1:0] lane_checksum, // per-lane parameter sum
    output logic [11:0] serdes_rate_x32, // lane rate multiplier times 32
    output logic encoding_64b66b, // 64b/66b selected
    output logic link_scramble_enable // scrambler requested
);
    logic link_en_ff;
    logic scr_ff;
    logic [3:0] fmt_ff;
    logic [7:0] did_ff;
    logic [7:0] km1_ff;
    logic [15:0] sclk_ff;
    logic fmt_rej_ff;
    logic km1_rej_ff;
    logic lock_rej_ff;
    logic [31:0] prdata_ff;
    logic active_ff;
    logic [8:0] fcnt_ff;
    logic frame_valid_ff;
    logic mf_start_ff;
    logic [LANES*FRAME_W-1:0] frame_ff;
    logic [LANES-1:0] pdown_ff;
    logic [LANES*8-1:0] csum_ff;
    logic [11:0] rate_ff;
    logic enc64_ff;

    logic enc64;
    logic [3:0] cur_n;
    logic [3:0] cur_l;
    logic [3:0] cur_m;
    logic [3:0] cur_f;
    logic [3:0] cur_s;
    logic [1:0] cur_hd;
    logic [1:0] cur_e;
    logic [8:0] cur_kstep;
    logic [15:0] cur_fmax;
    logic [2:0] cur_nch;
    logic [4:0] cur_spc;
    logic cur_il;
    logic [8:0] cur_k;
    logic k_ok;
    logic clk_bad;

    // format lookup
    assign enc64 = MSTM_TBL_ENC64[fmt_ff];
    assign cur_n = MSTM_TBL_N[fmt_ff];
    assign cur_l = MSTM_TBL_L[fmt_ff];
    assign cur_m = MSTM_TBL_M[fmt_ff];
    assign cur_f = MSTM_TBL_F[fmt_ff];
    assign cur_s = MSTM_TBL_S[fmt_ff];
    assign cur_hd = MSTM_TBL_HD[fmt_ff];
    assign cur_e = MSTM_TBL_E[fmt_ff];
    assign cur_kstep = MSTM_TBL_KSTEP[fmt_ff];
    assign cur_fmax = MSTM_TBL_FMAX[fmt_ff];
    assign cur_nch = MSTM_TBL_NCH[fmt_ff];
    assign cur_spc = MSTM_TBL_SPC[fmt_ff];
    // converters above channels: lanes in time order
    assign cur_il = {1'b0, cur_m} > {1'b0, cur_nch};

    always_comb begin
        if (enc64) begin
            cur_k = 9'((MSTM_EMB_FRAMES * 10'(cur_e)) / 10'(cur_f));
        end else begin
            cur_k = 9'(km1_ff) + 9'h001;
        end
    end

    // steps are powers of two; K fits 256 by width
    assign k_ok = enc64 || ((cur_k & (cur_kstep - 9'h001)) == 9'h000);
    assign clk_bad = (sclk_ff < MSTM_FCLK_MIN) || (sclk_ff > cur_fmax);

    // apb decode; zero wait states
    logic apb_setup;
    logic apb_write;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_mframe;
    logic wr_sclk;
    logic wr_status;
    logic [31:0] ctrl_rd;
    logic [31:0] status_rd;
    logic [31:0] rd_mux;
    logic [31:0] nxt_ctrl;
    logic [7:0] nxt_km1;
    logic [8:0] nxt_k;
    logic [4:0] nxt_fmt;
    logic cfg_change;

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_ff;
    assign wr_ctrl = apb_write && (paddr == MSTM_CTRL_OFS);
    assign wr_mframe = apb_write && (paddr == MSTM_MFRAME_OFS);
    assign wr_sclk = apb_write && (paddr == MSTM_SCLK_OFS);
    assign wr_status = apb_write && (paddr == MSTM_STATUS_OFS) && pstrb[0];

    always_comb begin
        unique case (paddr)
            MSTM_CTRL_OFS, MSTM_MFRAME_OFS, MSTM_SCLK_OFS, MSTM_STATUS_OFS,
            MSTM_PARAMS_OFS, MSTM_KRATE_OFS, MSTM_LANES_OFS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[MSTM_CTRL_EN_BIT] = link_en_ff;
        ctrl_rd[MSTM_CTRL_SCR_BIT] = scr_ff;
        ctrl_rd[MSTM_CTRL_FMT_LSB +: 5] = {1'b0, fmt_ff};
        ctrl_rd[MSTM_CTRL_DID_LSB +: 8] = did_ff;
        status_rd = '0;
        status_rd[MSTM_ST_FMT_REJ_BIT] = fmt_rej_ff;
        status_rd[MSTM_ST_KM1_REJ_BIT] = km1_rej_ff;
        status_rd[MSTM_ST_LOCK_REJ_BIT] = lock_rej_ff;
        status_rd[MSTM_ST_K_BAD_BIT] = !k_ok;
        status_rd[MSTM_ST_CLK_BAD_BIT] = clk_bad;
        status_rd[MSTM_ST_ACTIVE_BIT] = active_ff;
        status_rd[MSTM_ST_ENC64_BIT] = enc64;
    end

    always_comb begin
        unique case (paddr)
            MSTM_CTRL_OFS: rd_mux = ctrl_rd;
            MSTM_MFRAME_OFS: rd_mux = {24'h000000, km1_ff};
            MSTM_SCLK_OFS: rd_mux = {16'h0000, sclk_ff};
            MSTM_STATUS_OFS: rd_mux = status_rd;
            MSTM_PARAMS_OFS: rd_mux = {6'h00, cur_e, 1'b0, cur_hd, 1'b0, cur_n, cur_s, cur_f, cur_m, cur_l};
            MSTM_KRATE_OFS: rd_mux = {4'h0, MSTM_TBL_RATE32[fmt_ff], 7'h00, cur_k};
            MSTM_LANES_OFS: rd_mux = {24'h000000, ~pdown_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    assign nxt_ctrl = strb_merge(ctrl_rd, pwdata, pstrb);
    assign nxt_fmt = nxt_ctrl[MSTM_CTRL_FMT_LSB +: 5];
    assign nxt_km1 = 8'(strb_merge({24'h000000, km1_ff}, pwdata, pstrb));
    assign nxt_k = 9'(nxt_km1) + 9'h001;
    assign cfg_change = (nxt_fmt != {1'b0, fmt_ff}) || (nxt_ctrl[MSTM_CTRL_SCR_BIT] != scr_ff)
        || (nxt_ctrl[MSTM_CTRL_DID_LSB +: 8] != did_ff);

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    // configuration locked while the link runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_en_ff <= 1'b0;
            scr_ff <= 1'b0;
            fmt_ff <= MSTM_FMT_RST;
            did_ff <= MSTM_DID_RST;
        end else if (wr_ctrl) begin
            link_en_ff <= nxt_ctrl[MSTM_CTRL_EN_BIT];
            if (!link_en_ff) begin
                scr_ff <= nxt_ctrl[MSTM_CTRL_SCR_BIT];
                did_ff <= nxt_ctrl[MSTM_CTRL_DID_LSB +: 8];
                if (nxt_fmt < 5'(MSTM_MODES)) begin
                    fmt_ff <= nxt_fmt[3:0];
                end
            end
        end
    end

    // frame count only on this code's step grid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            km1_ff <= MSTM_KM1_RST;
        end else if (wr_mframe && !link_en_ff && !enc64 && ((nxt_k & (cur_kstep - 9'h001)) == 9'h000)) begin
            km1_ff <= nxt_km1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_ff <= MSTM_SCLK_RST;
        end else if (wr_sclk) begin
            sclk_ff <= 16'(strb_merge({16'h0000, sclk_ff}, pwdata, pstrb));
        end
    end

    // sticky refusals; write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_rej_ff <= 1'b0;
            km1_rej_ff <= 1'b0;
            lock_rej_ff <= 1'b0;
        end else begin
            fmt_rej_ff <= (wr_ctrl && !link_en_ff && (nxt_fmt >= 5'(MSTM_MODES)))
                || (fmt_rej_ff && !(wr_status && pwdata[MSTM_ST_FMT_REJ_BIT]));
            km1_rej_ff <= (wr_mframe && (link_en_ff || enc64 || ((nxt_k & (cur_kstep - 9'h001)) != 9'h000)))
                || (km1_rej_ff && !(wr_status && pwdata[MSTM_ST_KM1_REJ_BIT]));
            lock_rej_ff <= (wr_ctrl && link_en_ff && cfg_change)
                || (lock_rej_ff && !(wr_status && pwdata[MSTM_ST_LOCK_REJ_BIT]));
        end
    end

    // link runs only with a legal K
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= link_en_ff && k_ok;
        end
    end

    assign sample_ready = active_ff;

    logic take;
    logic [FRAME_W-1:0] packed_frame [LANES];

    assign take = sample_valid && active_ff;

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            logic [7:0] csum;

            mstm_lane_pack #(
                .LANE(gl),
                .SMP_W(SMP_W),
                .NCH(NCH),
                .SPC(SPC),
                .FRAME_W(FRAME_W)
            ) u_pack (
                .cfg_n(cur_n),
                .cfg_f(cur_f),
                .cfg_nch(cur_nch),
                .cfg_spc(cur_spc),
                .cfg_interleave(cur_il),
                .sample_data(sample_data),
                .frame(packed_frame[gl])
            );

            assign lane_index_identifier[gl*5 +: 5] = 5'(gl);

            // parameters in minus-one form
            assign csum = did_ff + 8'(gl) + {7'h00, scr_ff} + 8'(cur_l - 4'h1) + 8'(cur_f - 4'h1)
                + 8'(cur_k - 9'h001) + 8'(cur_m - 4'h1) + 8'(cur_n - 4'h1) + 8'(cur_n - 4'h1)
                + 8'(cur_s - 4'h1) + {6'h00, cur_hd} + MSTM_JESDV + MSTM_SUBCLASSV;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    frame_ff[gl*FRAME_W +: FRAME_W] <= '0;
                    pdown_ff[gl] <= 1'b1;
                    csum_ff[gl*8 +: 8] <= 8'h00;
                end else begin
                    if (take) begin
                        frame_ff[gl*FRAME_W +: FRAME_W] <= (gl < int'(cur_l)) ? packed_frame[gl] : '0;
                    end
                    pdown_ff[gl] <= !(active_ff && (gl < int'(cur_l)));
                    csum_ff[gl*8 +: 8] <= csum;
                end
            end
        end
    endgenerate

    // multiframe marking; restarts when the link stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_ff <= 9'h000;
            frame_valid_ff <= 1'b0;
            mf_start_ff <= 1'b0;
        end else begin
            frame_valid_ff <= take;
            mf_start_ff <= take && (fcnt_ff == 9'h000);
            if (!active_ff) begin
                fcnt_ff <= 9'h000;
            end else if (take) begin
                fcnt_ff <= (fcnt_ff == cur_k - 9'h001) ? 9'h000 : fcnt_ff + 9'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_ff <= 12'h000;
            enc64_ff <= 1'b0;
        end else begin
            rate_ff <= MSTM_TBL_RATE32[fmt_ff];
            enc64_ff <= enc64;
        end
    end

    assign lane_frame_data = frame_ff;
    assign lane_frame_valid = frame_valid_ff;
    assign multiframe_start = mf_start_ff;
    assign lane_power_down = pdown_ff;
    assign link_device_identifier = did_ff;
    assign lane_checksum = csum_ff;
    assign serdes_rate_x32 = rate_ff;
    assign encoding_64b66b = enc64_ff;
    assign link_scramble_enable = scr_ff;
endmodule

//--- verification/mstm_chk.sv
/* mstm_chk: port assertions for the mapper.
   Assumes a bind onto mstm_mapper with default widths. */
`timescale 1ns/1ps
module mstm_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic sample_valid, // frame offered
    input wire logic sample_ready, // frame taken
    input wire logic lane_frame_valid, // frame out
    input wire logic multiframe_start, // multiframe opens
    input wire logic [511:0] lane_frame_data, // frames
    input wire logic [7:0] lane_power_down, // lanes off
    input wire logic [39:0] lane_index_identifier, // lane ids
    input wire logic [7:0] link_device_identifier, // device id
    input wire logic [11:0] serdes_rate_x32, // rate
    input wire logic encoding_64b66b // coding
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_take_frame: assert property (sample_valid && sample_ready |=> lane_frame_valid)
        else $error("no frame after take");
    a_no_take: assert property (!(sample_valid && sample_ready) |=> !lane_frame_valid)
        else $error("frame without take");
    a_mf_in_frame: assert property (multiframe_start |-> lane_frame_valid)
        else $error("multiframe start outside frame");
    a_lane_ids: assert property (lane_index_identifier == 40'h398A418820)
        else $error("lane id wrong");
    a_code0_lanes: assert property ((serdes_rate_x32 == 12'h100 && sample_ready) [*3] |->
        lane_power_down == 8'h00 && !encoding_64b66b)
        else $error("mode 0 lanes wrong");
    a_code8_lanes: assert property ((serdes_rate_x32 == 12'h18C && sample_ready) [*3] |->
        lane_power_down == 8'hF0 && encoding_64b66b)
        else $error("mode 8 lanes wrong");
    a_tail_zero: assert property (lane_frame_valid && serdes_rate_x32 == 12'h100 |->
        lane_frame_data[3:0] == 4'h0 && lane_frame_data[451:448] == 4'h0)
        else $error("tail bits not zero");
    a_did_hold: assert property (sample_ready && $past(sample_ready) |-> $stable(link_device_identifier))
        else $error("device id moved");
endmodule
bind mstm_mapper mstm_chk mstm_chk_inst (.pclk(pclk), .presetn(presetn), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .lane_frame_valid(lane_frame_valid), .multiframe_start(multiframe_start),
    .lane_frame_data(lane_frame_data), .lane_power_down(lane_power_down), .encoding_64b66b(encoding_64b66b),
    .lane_index_identifier(lane_index_identifier), .link_device_identifier(link_device_identifier),
    .serdes_rate_x32(serdes_rate_x32));

//--- verification/mstm_rx_model.sv
/* mstm_rx_model: far-side receiver; counts frames and multiframes and
   rebuilds channel a from lanes 0 and 1. Assumes the 8-lane mode 0 map. */
`timescale 1ns/1ps
module mstm_rx_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic lane_frame_valid, // frame strobe
    input wire logic multiframe_start, // multiframe opens
    input wire logic [511:0] lane_frame_data, // all lanes
    output logic [15:0] n_frm_ff, // frames seen
    output logic [15:0] n_mf_ff, // multiframes seen
    output logic [119:0] rec_a_ff // channel a, samples 0..9
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_frm_ff <= 16'h0000;
            n_mf_ff <= 16'h0000;
            rec_a_ff <= '0;
        end else if (lane_frame_valid) begin
            n_frm_ff <= n_frm_ff + 16'h0001;
            n_mf_ff <= n_mf_ff + {15'h0000, multiframe_start};
            for (int k = 0; k < 5; k++) begin
                rec_a_ff[119 - 24 * k -: 12] <= lane_frame_data[63 - 12 * k -: 12];
                rec_a_ff[107 - 24 * k -: 12] <= lane_frame_data[127 - 12 * k -: 12];
            end
        end
    end
endmodule

//--- verification/tb.sv
/* tb: register and stream tests for mstm_mapper.
   Assumes a 250 MHz pclk and the zero-wait APB slave of the mapper. */
`timescale 1ns/1ps
module tb;
    import mstm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, sample_ready, er;
    logic lane_frame_valid, multiframe_start, encoding_64b66b, link_scramble_enable;
    logic [7:0] paddr, lane_power_down, link_device_identifier;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [959:0] sample_data;
    logic [511:0] lane_frame_data;
    logic [39:0] lane_index_identifier;
    logic [63:0] lane_checksum, ex;
    logic [11:0] serdes_rate_x32;
    logic [15:0] n_frm, n_mf;
    logic [119:0] rec_a;
    logic [8:0] kx;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] prm [0:15] = '{32'h000C5888, 32'h002C2246, 32'h00081144, 32'h000A4544, 32'h012C1243,
        32'h01081242, 32'h012C2246, 32'h01081144, 32'h030C2344, 32'h00082148, 32'h000A4588, 32'h000C5888,
        32'h00084128, 32'h000A4588, 32'h030C2388, 32'h034C2388};
    mstm_mapper mstm_mapper_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
        .lane_frame_data(lane_frame_data), .lane_frame_valid(lane_frame_valid),
        .multiframe_start(multiframe_start), .lane_power_down(lane_power_down),
        .lane_index_identifier(lane_index_identifier), .link_device_identifier(link_device_identifier),
        .lane_checksum(lane_checksum), .serdes_rate_x32(serdes_rate_x32), .encoding_64b66b(encoding_64b66b),
        .link_scramble_enable(link_scramble_enable));
    mstm_rx_model mstm_rx_model_inst (.pclk(pclk), .presetn(presetn), .lane_frame_valid(lane_frame_valid),
        .multiframe_start(multiframe_start), .lane_frame_data(lane_frame_data), .n_frm_ff(n_frm),
        .n_mf_ff(n_mf), .rec_a_ff(rec_a));
    function automatic logic [11:0] v(int ch, int s);
        return 12'(ch * 256 + s * 9 + 1);
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task complete_run;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #100000;
        n_fail++;
        complete_run;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        sample_valid = 1'b0;
        for (int i = 0; i < 960; i += 12) sample_data[i +: 12] = v(i / 240, (i / 12) % 20);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            apb(MSTM_CTRL_OFS, 1'b1, 32'(c) << 8 | 32'h1);
            apb(MSTM_PARAMS_OFS, 1'b0, 32'h0);
            chk("params", prm[c], rd);
            chk("rate", MSTM_TBL_RATE32[c], serdes_rate_x32);
            kx = prm[c][25:24] != 2'h0 ? 9'(256 * prm[c][25:24] / prm[c][11:8]) : 9'h020;
            apb(MSTM_KRATE_OFS, 1'b0, 32'h0);
            chk("krate", {4'h0, MSTM_TBL_RATE32[c], 7'h00, kx}, rd);
            apb(MSTM_LANES_OFS, 1'b0, 32'h0);
            chk("lanes", 8'hFF >> (8 - prm[c][3:0]), rd);
            apb(MSTM_CTRL_OFS, 1'b1, 32'(c) << 8);
        end
        $display("test formats done");
        apb(MSTM_CTRL_OFS, 1'b1, 32'h00001000);
        apb(MSTM_PARAMS_OFS, 1'b0, 32'h0);
        chk("bad code", prm[15], rd);
        apb(MSTM_STATUS_OFS, 1'b0, 32'h0);
        chk("code refused", 1'b1, rd[0]);
        apb(MSTM_CTRL_OFS, 1'b1, 32'h005A0000);
        apb(MSTM_MFRAME_OFS, 1'b1, 32'h02);
        apb(MSTM_MFRAME_OFS, 1'b0, 32'h0);
        chk("k refused", 32'h1F, rd);
        apb(MSTM_MFRAME_OFS, 1'b1, 32'h03);
        apb(MSTM_CTRL_OFS, 1'b1, 32'h005A0001);
        apb(MSTM_CTRL_OFS, 1'b1, 32'h00000301);
        apb(MSTM_PARAMS_OFS, 1'b0, 32'h0);
        chk("locked", prm[0], rd);
        $display("test config done");
        @(posedge pclk);
        sample_valid <= 1'b1;
        repeat (8) @(posedge pclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("frames", 16'h0008, n_frm);
        chk("mf starts", 16'h0002, n_mf);
        for (int i = 0; i < 8; i++) begin
            ex = 64'h0;
            for (int k = 0; k < 5; k++) ex[63 - 12 * k -: 12] = v(i / 2, 2 * k + i % 2);
            chk("lane frame", ex, lane_frame_data[i * 64 +: 64]);
            chk("checksum", 8'h8E + 8'(i), lane_checksum[i * 8 +: 8]);
        end
        for (int s = 0; s < 10; s++) chk("rx sample", v(0, s), rec_a[119 - 12 * s -: 12]);
        chk("did scr", 9'h0B4, {link_device_identifier, link_scramble_enable});
        apb(8'h1C, 1'b0, 32'h0);
        chk("unmapped", 33'h100000000, {er, rd});
        $display("test stream done");
        complete_run;
    end
endmodule
